// ==== src/ocd_pkg.sv ====
// Shared opcodes, phase states and constants for the one-bit control processor
package ocd_pkg;

	// ****************************************************************
	// Widths and reset values
	// ****************************************************************
	localparam int   NIBBLE_W  = 4;
	localparam logic BIT_CLEAR = 1'b0;
	localparam logic BIT_SET   = 1'b1;

	typedef logic [NIBBLE_W-1:0] ocd_op_t;

	// ****************************************************************
	// Operation codes, presented on the nibble bus while the clock is high
	// ****************************************************************
	localparam ocd_op_t OP_FLAG_ZERO     = 4'h0;
	localparam ocd_op_t OP_LOAD_RESULT   = 4'h1;
	localparam ocd_op_t OP_LOAD_COMP     = 4'h2;
	localparam ocd_op_t OP_AND           = 4'h3;
	localparam ocd_op_t OP_AND_COMP      = 4'h4;
	localparam ocd_op_t OP_OR            = 4'h5;
	localparam ocd_op_t OP_OR_COMP       = 4'h6;
	localparam ocd_op_t OP_XNOR          = 4'h7;
	localparam ocd_op_t OP_STORE_RESULT  = 4'h8;
	localparam ocd_op_t OP_STORE_COMP    = 4'h9;
	localparam ocd_op_t OP_INPUT_GATE    = 4'hA;
	localparam ocd_op_t OP_OUTPUT_GATE   = 4'hB;
	localparam ocd_op_t OP_JUMP          = 4'hC;
	localparam ocd_op_t OP_RETURN        = 4'hD;
	localparam ocd_op_t OP_SKIP_ZERO     = 4'hE;
	localparam ocd_op_t OP_RESTART_PULSE = 4'hF;

	// ****************************************************************
	// Half-cycle tracking of the processor clock
	// ****************************************************************
	typedef enum logic [1:0] {
		PH_HIGH   = 2'b00,
		PH_SETTLE = 2'b01,
		PH_LOW    = 2'b10
	} ocd_phase_e;

endpackage

// ==== src/ocd_alu_if.sv ====
// Carrier between the processor core and its instruction decoder
`timescale 1ns/100ps
interface ocd_alu_if;
	import ocd_pkg::*;

	ocd_op_t op;           // Latched operation code
	logic    din;          // Input bit after the input gate
	logic    din_raw;      // Input bit before the input gate
	logic    rr;           // Present result register
	logic    rr_next;      // Result register after the instruction
	logic    wr_req;       // Instruction wants an output write
	logic    wr_val;       // Value for the output latch
	logic    in_gate_ld;   // Load the input gate register
	logic    out_gate_ld;  // Load the output gate register
	logic    flag_zero;    // Flag-zero pulse request
	logic    flag_jump;    // Jump pulse request
	logic    flag_return;  // Return pulse request
	logic    flag_restart; // Restart pulse request
	logic    skip_req;     // Skip the following instruction

	modport core (
		output op, din, din_raw, rr,
		input  rr_next, wr_req, wr_val, in_gate_ld, out_gate_ld,
		input  flag_zero, flag_jump, flag_return, flag_restart, skip_req
	);
	modport alu (
		input  op, din, din_raw, rr,
		output rr_next, wr_req, wr_val, in_gate_ld, out_gate_ld,
		output flag_zero, flag_jump, flag_return, flag_restart, skip_req
	);
endinterface

// ==== src/ocd_alu.sv ====
// Combinational decoder: result logic and side effects of each opcode
`timescale 1ns/100ps
module ocd_alu
	import ocd_pkg::*;
(
	ocd_alu_if.alu bus // Operands in, effects out
);

	// ****************************************************************
	// Decode
	// ****************************************************************
	// Every output is defaulted; opcode 0 falls to the default branch and raises flag_zero
	always_comb begin
		bus.rr_next      = bus.rr;
		bus.wr_req       = 1'b0;
		bus.wr_val       = bus.rr;
		bus.in_gate_ld   = 1'b0;
		bus.out_gate_ld  = 1'b0;
		bus.flag_zero    = 1'b0;
		bus.flag_jump    = 1'b0;
		bus.flag_return  = 1'b0;
		bus.flag_restart = 1'b0;
		bus.skip_req     = 1'b0;
		case (bus.op)
			OP_LOAD_RESULT:   bus.rr_next = bus.din;
			OP_LOAD_COMP:     bus.rr_next = ~bus.din;
			OP_AND:           bus.rr_next = bus.rr & bus.din;
			OP_AND_COMP:      bus.rr_next = bus.rr & ~bus.din;
			OP_OR:            bus.rr_next = bus.rr | bus.din;
			OP_OR_COMP:       bus.rr_next = bus.rr | ~bus.din;
			OP_XNOR:          bus.rr_next = ~(bus.rr ^ bus.din);
			OP_STORE_RESULT:  bus.wr_req  = 1'b1;
			OP_STORE_COMP: begin
				bus.wr_req = 1'b1;
				bus.wr_val = ~bus.rr;
			end
			// Gate registers load from the raw bit, else a closed gate could never reopen
			OP_INPUT_GATE:    bus.in_gate_ld   = 1'b1;
			OP_OUTPUT_GATE:   bus.out_gate_ld  = 1'b1;
			OP_JUMP:          bus.flag_jump    = 1'b1;
			OP_RETURN: begin
				bus.flag_return = 1'b1;
				bus.skip_req    = 1'b1;
			end
			OP_SKIP_ZERO:     bus.skip_req     = ~bus.rr;
			OP_RESTART_PULSE: bus.flag_restart = 1'b1;
			default:          bus.flag_zero    = 1'b1;
		endcase
	end

endmodule // ocd_alu

// ==== src/ocd_core.sv ====
// One-bit control processor core: phase tracking, registers, output strobes
// Behaviour
// - Load copies input bit into result.
// - AND input bit into result register.
// - OR input bit into result register.
// - Store drives result to addressed latch.
// - Store leaves result register unchanged.
// - Restart opcode pulses restart output.
// - Restart opcode ignores its operand nibble.
// - Store strobe happens in low phase.
// - Closed input gate forces inputs zero.
// - Closed output gate suppresses write strobe.
`timescale 1ns/100ps
module ocd_core
	import ocd_pkg::*;
(
	input  wire logic                i_clk,          // 10 MHz system clock
	input  wire logic                i_nrst,         // Asynchronous reset, active low
	input  wire logic                i_proc_clk,     // Processor phase clock pin
	input  wire logic [NIBBLE_W-1:0] i_mem_data,     // Program memory nibble
	input  wire logic                i_in_bit,       // Selected input bit
	output logic                     o_write,        // Output latch write strobe
	output logic                     o_out_data,     // Data for the output latch
	output logic [NIBBLE_W-1:0]      o_io_addr,      // Address of the instruction
	output logic                     o_restart,      // Restart pulse to preset counter
	output logic                     o_flag_zero,    // Flag-zero pulse
	output logic                     o_jump,         // Jump pulse
	output logic                     o_return,       // Return pulse
	output logic                     o_result,       // Result register
	output logic                     o_input_gate,   // Input gate register
	output logic                     o_output_gate   // Output gate register
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic                clk_meta_reg;
	logic                clk_sync_reg;
	logic [NIBBLE_W-1:0] data_meta_reg;
	logic [NIBBLE_W-1:0] data_sync_reg;
	logic                bit_meta_reg;
	logic                bit_sync_reg;
	ocd_phase_e          phase_reg;
	ocd_op_t             op_reg;
	logic                rr_reg;
	logic                input_gate_reg;
	logic                output_gate_reg;
	logic                skip_reg;
	logic                write_reg;
	logic                out_data_reg;
	logic [NIBBLE_W-1:0] addr_reg;
	logic                restart_reg;
	logic                flag_zero_reg;
	logic                jump_reg;
	logic                return_reg;
	logic                exec_pulse;
	logic                exec_ok;
	logic                din_eff;

	ocd_alu_if alu_bus ();

	ocd_alu u_alu (
		.bus (alu_bus.alu)
	);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	// Pins come from the panel and memory; two flops each before use
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			clk_meta_reg  <= BIT_SET;
			clk_sync_reg  <= BIT_SET;
			data_meta_reg <= '0;
			data_sync_reg <= '0;
			bit_meta_reg  <= BIT_CLEAR;
			bit_sync_reg  <= BIT_CLEAR;
		end else begin
			clk_meta_reg  <= i_proc_clk;
			clk_sync_reg  <= clk_meta_reg;
			data_meta_reg <= i_mem_data;
			data_sync_reg <= data_meta_reg;
			bit_meta_reg  <= i_in_bit;
			bit_sync_reg  <= bit_meta_reg;
		end
	end

	// ****************************************************************
	// Phase tracking
	// ****************************************************************
	// One settle cycle after the fall lets the address nibble arrive
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			phase_reg <= PH_HIGH;
		end else begin
			case (phase_reg)
				PH_HIGH:   if (!clk_sync_reg) phase_reg <= PH_SETTLE;
				PH_SETTLE: phase_reg <= PH_LOW;
				PH_LOW:    if (clk_sync_reg) phase_reg <= PH_HIGH;
				default:   phase_reg <= PH_HIGH;
			endcase
		end
	end

	// Opcode follows the bus through the high half and freezes at the fall
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			op_reg <= OP_FLAG_ZERO;
		end else if (phase_reg == PH_HIGH && clk_sync_reg) begin
			op_reg <= data_sync_reg;
		end
	end

	// Execution happens once per instruction, inside the low half
	assign exec_pulse = (phase_reg == PH_SETTLE);
	assign exec_ok    = exec_pulse && !skip_reg;
	assign din_eff    = bit_sync_reg & input_gate_reg;

	assign alu_bus.op      = op_reg;
	assign alu_bus.din     = din_eff;
	assign alu_bus.din_raw = bit_sync_reg;
	assign alu_bus.rr      = rr_reg;

	// ****************************************************************
	// Processor registers
	// ****************************************************************
	// Result and gate registers change only on an executed instruction
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rr_reg          <= BIT_CLEAR;
			input_gate_reg  <= BIT_CLEAR;
			output_gate_reg <= BIT_CLEAR;
		end else if (exec_ok) begin
			rr_reg <= alu_bus.rr_next;
			if (alu_bus.in_gate_ld)
				input_gate_reg <= alu_bus.din_raw;
			if (alu_bus.out_gate_ld)
				output_gate_reg <= alu_bus.din_raw;
		end
	end

	// A skipped instruction only clears the skip; it never sets a new one
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			skip_reg <= BIT_CLEAR;
		end else if (exec_pulse) begin
			skip_reg <= !skip_reg && alu_bus.skip_req;
		end
	end

	// ****************************************************************
	// Output strobes
	// ****************************************************************
	// Pulses last one system clock; the address nibble is kept for the latches
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			write_reg     <= BIT_CLEAR;
			out_data_reg  <= BIT_CLEAR;
			addr_reg      <= '0;
			restart_reg   <= BIT_CLEAR;
			flag_zero_reg <= BIT_CLEAR;
			jump_reg      <= BIT_CLEAR;
			return_reg    <= BIT_CLEAR;
		end else begin
			write_reg     <= exec_ok && alu_bus.wr_req && output_gate_reg;
			restart_reg   <= exec_ok && alu_bus.flag_restart;
			flag_zero_reg <= exec_ok && alu_bus.flag_zero;
			jump_reg      <= exec_ok && alu_bus.flag_jump;
			return_reg    <= exec_ok && alu_bus.flag_return;
			if (exec_ok) begin
				out_data_reg <= alu_bus.wr_val;
				addr_reg     <= data_sync_reg;
			end
		end
	end

	assign o_write       = write_reg;
	assign o_out_data    = out_data_reg;
	assign o_io_addr     = addr_reg;
	assign o_restart     = restart_reg;
	assign o_flag_zero   = flag_zero_reg;
	assign o_jump        = jump_reg;
	assign o_return      = return_reg;
	assign o_result      = rr_reg;
	assign o_input_gate  = input_gate_reg;
	assign o_output_gate = output_gate_reg;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	property p_load;
		exec_ok && op_reg == OP_LOAD_RESULT |=> rr_reg == $past(din_eff);
	endproperty
	a_load: assert property (p_load) else $error("load did not copy input bit");

	property p_and;
		exec_ok && op_reg == OP_AND |=> rr_reg == ($past(din_eff) & $past(rr_reg));
	endproperty
	a_and: assert property (p_and) else $error("and result wrong");

	property p_or;
		exec_ok && op_reg == OP_OR |=> rr_reg == ($past(din_eff) | $past(rr_reg));
	endproperty
	a_or: assert property (p_or) else $error("or result wrong");

	property p_store;
		exec_ok && op_reg == OP_STORE_RESULT && output_gate_reg
			|=> o_write && o_out_data == $past(rr_reg) ##1 !o_write;
	endproperty
	a_store: assert property (p_store) else $error("store strobe or data wrong");

	property p_store_keep;
		exec_pulse && op_reg == OP_STORE_RESULT |=> $stable(rr_reg) [*2];
	endproperty
	a_store_keep: assert property (p_store_keep) else $error("store changed result");

	property p_restart;
		exec_ok && op_reg == OP_RESTART_PULSE |=> o_restart ##1 !o_restart;
	endproperty
	a_restart: assert property (p_restart) else $error("restart pulse missing");

	property p_restart_cause;
		o_restart |-> $past(exec_ok) && $past(op_reg) == OP_RESTART_PULSE;
	endproperty
	a_restart_cause: assert property (p_restart_cause) else $error("stray restart pulse");

	property p_write_low;
		o_write |-> phase_reg == PH_LOW && $past(phase_reg) == PH_SETTLE;
	endproperty
	a_write_low: assert property (p_write_low) else $error("write outside low phase");

	property p_gate_in;
		exec_ok && op_reg == OP_LOAD_RESULT && !input_gate_reg |=> !rr_reg;
	endproperty
	a_gate_in: assert property (p_gate_in) else $error("closed input gate leaked");

	property p_gate_out;
		exec_pulse && !output_gate_reg |=> !o_write;
	endproperty
	a_gate_out: assert property (p_gate_out) else $error("write with output gate closed");

endmodule // ocd_core

// ==== test/ocd_partner.sv ====
// Partner model: program memory, phase clock, input selector and output latches
`timescale 1ns/100ps
module ocd_partner
	import ocd_pkg::*;
#(
	parameter int HALF = 8 // System cycles per processor clock half
)(
	input  wire logic                i_clk,      // System clock
	input  wire logic                i_nrst,     // Halt/reset, active low
	input  wire logic                i_run,      // Run control
	input  wire logic                i_step,     // Single-step press, one toggle per cycle high
	input  wire logic [15:0]         i_inputs,   // Switch level per input address
	input  wire logic                i_result,   // Result register, wired to input zero
	input  wire logic                i_write,    // Latch write strobe
	input  wire logic                i_out_data, // Latch data
	input  wire logic [NIBBLE_W-1:0] i_io_addr,  // Latch address
	input  wire logic                i_restart,  // Restart pulse
	output logic                     o_proc_clk, // Processor phase clock
	output logic [NIBBLE_W-1:0]      o_mem_data, // Program nibble
	output logic                     o_in_bit,   // Selected input bit
	output logic [15:0]              o_latches,  // Output latches
	output logic [3:0]               o_pc        // Program counter
);
	ocd_op_t prog [0:31];
	int      cnt;
	logic    preset;
	logic    toggle;

	// Panel load of one nibble
	task automatic load(input int loc, input ocd_op_t val);
		prog[loc] = val;
	endtask

	// Even word is the opcode half, odd word the address half
	assign o_mem_data = prog[{o_pc, ~o_proc_clk}];
	// Input zero is tied to the result register, never to a switch
	assign o_in_bit = (o_mem_data == 4'h0) ? i_result : i_inputs[o_mem_data];
	// Run mode toggles every HALF cycles; step mode once per press
	assign toggle = i_run ? (cnt == HALF - 1) : i_step;

	// ****************************************************************
	// Counter and phase clock; halt/reset parks the clock high
	// ****************************************************************
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_proc_clk <= 1'b1;
			o_pc       <= 4'h0;
			cnt        <= 0;
			preset     <= 1'b0;
		end else begin
			if (i_restart) begin
				preset <= 1'b1;
			end
			cnt <= (i_run && !toggle) ? cnt + 1 : 0;
			if (toggle) begin
				o_proc_clk <= ~o_proc_clk;
				if (!o_proc_clk) begin
					o_pc   <= preset ? 4'h0 : o_pc + 4'h1;
					preset <= 1'b0;
				end
			end
		end
	end

	// Output latches follow the write strobe only
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_latches <= 16'h0000;
		end else if (i_write) begin
			o_latches[i_io_addr] <= i_out_data;
		end
	end
endmodule // ocd_partner

// ==== test/test_one_bit_control_demo_system.sv ====
// Self-checking bench: runs small programs through the core and its partner
`timescale 1ns/100ps
module test_one_bit_control_demo_system;
	import ocd_pkg::*;

	logic                clk, nrst, run, step, proc_clk, in_bit, write, out_data, restart, result;
	logic                in_gate, out_gate, flag_zero, jump, ret;
	logic [NIBBLE_W-1:0] mem_data, io_addr;
	logic [15:0]         inputs, latches;
	logic [3:0]          pc;
	logic [7:0]          code [0:7];
	int                  bad_count, checked, restarts, zeros, jumps, returns;
	logic                a, b, c, y;

	ocd_partner part (.i_clk(clk), .i_nrst(nrst), .i_run(run), .i_inputs(inputs), .i_result(result),
		.i_step(step), .i_write(write), .i_out_data(out_data), .i_io_addr(io_addr), .i_restart(restart),
		.o_proc_clk(proc_clk), .o_mem_data(mem_data), .o_in_bit(in_bit), .o_latches(latches), .o_pc(pc));

	ocd_core uut (.i_clk(clk), .i_nrst(nrst), .i_proc_clk(proc_clk), .i_mem_data(mem_data),
		.i_in_bit(in_bit), .o_write(write), .o_out_data(out_data), .o_io_addr(io_addr),
		.o_restart(restart), .o_flag_zero(flag_zero), .o_jump(jump), .o_return(ret), .o_result(result),
		.o_input_gate(in_gate), .o_output_gate(out_gate));

	// 10 MHz system clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: %s saw %h expected %h", $time, what, seen, exp);
		end
	endtask

	// One instruction ends when the processor clock returns high
	task automatic wait_rise();
		logic prev;
		prev = proc_clk;
		for (int n = 0; n < 40; n++) begin
			@(posedge clk);
			#1;
			if (proc_clk === 1'b1 && prev === 1'b0) return;
			prev = proc_clk;
		end
		bad_count++;
		$display("Error at %0t: processor clock stalled", $time);
		give_verdict();
	endtask

	// Load the program, then halt/reset for 8 cycles; release on an edge, running or stepping
	task automatic boot(input logic go);
		for (int i = 0; i < 8; i++) begin
			part.load(2 * i, code[i][7:4]);
			part.load(2 * i + 1, code[i][3:0]);
		end
		@(posedge clk);
		nrst <= 1'b0;
		run  <= 1'b0;
		repeat (8) @(posedge clk);
		#1;
		restarts = 0;
		zeros    = 0;
		jumps    = 0;
		returns  = 0;
		check(latches, 16'h0000, "latches after halt");
		check(pc, 4'h0, "counter after halt");
		check(result, 1'b0, "result after halt");
		@(posedge clk);
		nrst <= 1'b1;
		run  <= go;
		#1;
	endtask

	// One press of the step control, then time for the core to execute
	task automatic step_once();
		@(posedge clk);
		step <= 1'b1;
		@(posedge clk);
		step <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
	endtask

	// Write strobes only in the execute half, and never with the output gate shut
	always @(posedge clk) begin
		if (write === 1'b1) begin
			check(proc_clk, 1'b0, "write in opcode half");
			check(out_gate, 1'b1, "write with gate shut");
		end
		if (restart === 1'b1) restarts++;
		if (flag_zero === 1'b1) zeros++;
		if (jump === 1'b1) jumps++;
		if (ret === 1'b1) returns++;
	end

	initial begin
		nrst      = 1'b0;
		run       = 1'b0;
		step      = 1'b0;
		inputs    = 16'h0000;
		bad_count = 0;
		checked   = 0;
		// ************************************************************
		// Relay ladder program for every switch combination
		// ************************************************************
		code = '{8'hA6, 8'hB6, 8'h11, 8'h32, 8'h53, 8'h81, 8'hF7, 8'hF7};
		for (int k = 0; k < 8; k++) begin
			{c, b, a} = k[2:0];
			y = (a & b) | c;
			inputs <= {9'h000, 1'b1, 2'b00, c, b, a, 1'b0};
			boot(1'b1);
			wait_rise();
			check(in_gate, 1'b1, "input gate");
			wait_rise();
			check(out_gate, 1'b1, "output gate");
			wait_rise();
			check(result, a, "load");
			wait_rise();
			check(result, a & b, "and");
			wait_rise();
			check(result, y, "or");
			wait_rise();
			check(latches[1], y, "store latch");
			check(result, y, "result after store");
			check(pc, 4'h6, "counter step");
			wait_rise();
			check(pc, 4'h0, "counter preset");
			check(16'(restarts), 16'h0001, "restart pulses");
			check(result, y, "result after restart");
		end
		$display("Test ladder done");
		// ************************************************************
		// Both gates shut through input zero
		// ************************************************************
		code = '{8'hA0, 8'hB0, 8'h16, 8'h26, 8'h81, 8'hF7, 8'hF7, 8'hF7};
		inputs <= 16'h0046;
		boot(1'b1);
		wait_rise();
		wait_rise();
		check({in_gate, out_gate}, 2'b00, "gates from input zero");
		wait_rise();
		check(result, 1'b0, "load through shut gate");
		wait_rise();
		check(result, 1'b1, "load complement through shut gate");
		wait_rise();
		check(latches, 16'h0000, "store with gate shut");
		wait_rise();
		check(pc, 4'h0, "counter preset");
		$display("Test gates done");
		// ************************************************************
		// Single-step read-out after halt/reset
		// ************************************************************
		boot(1'b0);
		check(mem_data, 4'hA, "first nibble at location zero");
		step_once();
		check(proc_clk, 1'b0, "one press is half a cycle");
		check(mem_data, 4'h0, "second nibble");
		step_once();
		check(pc, 4'h1, "counter after two presses");
		check(mem_data, 4'hB, "third nibble");
		$display("Test step done");
		// ************************************************************
		// Complement and exclusive-nor operations
		// ************************************************************
		code = '{8'hB6, 8'hA6, 8'h62, 8'h41, 8'h72, 8'h72, 8'h93, 8'hF7};
		inputs <= 16'h0042;
		boot(1'b1);
		repeat (2) wait_rise();
		check({in_gate, out_gate}, 2'b11, "gates open");
		wait_rise();
		check(result, 1'b1, "or complement");
		wait_rise();
		check(result, 1'b0, "and complement");
		wait_rise();
		check(result, 1'b1, "exclusive nor");
		wait_rise();
		check(result, 1'b0, "exclusive nor again");
		wait_rise();
		check(latches, 16'h0008, "store complement");
		check(result, 1'b0, "result after store complement");
		wait_rise();
		check(pc, 4'h0, "counter preset");
		$display("Test operations done");
		// ************************************************************
		// Skips and flag pulses
		// ************************************************************
		code = '{8'hB6, 8'hE0, 8'h91, 8'hC0, 8'hD0, 8'h91, 8'h05, 8'hF7};
		boot(1'b1);
		repeat (3) wait_rise();
		check(latches, 16'h0000, "store after skip if zero");
		wait_rise();
		check(16'(jumps), 16'h0001, "jump pulse");
		wait_rise();
		check(16'(returns), 16'h0001, "return pulse");
		wait_rise();
		check(latches, 16'h0000, "store after return");
		wait_rise();
		check(16'(zeros), 16'h0001, "flag zero pulse");
		wait_rise();
		check(pc, 4'h0, "counter preset");
		check(16'(restarts), 16'h0001, "restart pulses");
		$display("Test skips done");
		give_verdict();
	end
endmodule // test_one_bit_control_demo_system
